// ==== common/bsd_map.svh ====
`ifndef BSD_MAP_SVH
`define BSD_MAP_SVH
// clock and serial rates
`define BSD_CLK_HZ 100000000
`define BSD_BAUD_FAST 8192
`define BSD_BAUD_SLOW 1200
`define BSD_BAUD_F0 9600
`define BSD_BAUD_FD 5208
// sync characters
`define BSD_SYNC_ONES 8'hFF
`define BSD_SYNC_F0 8'hF0
`define BSD_SYNC_FD 8'hFD
`define BSD_SYNC_ZERO 8'h00
// idle timeouts in bit times (ten bits to a character)
`define BSD_TO_FOUR 8'd40
`define BSD_TO_F0 8'd49
`define BSD_TO_FD 8'd173
// download sizes and jump targets
`define BSD_FIXED_LEN 10'd256
`define BSD_RAM_BYTES 10'd512
`define BSD_RAM_BASE 16'h0000
`define BSD_EEPROM_BASE 16'hB600
`define BSD_BOOT_LO 16'hBF00
`define BSD_BOOT_HI 16'hBFFF
`define BSD_FIFO_DEPTH 8
`endif

// ==== common/bsd_pkg.sv ====
package bsd_pkg;
  typedef enum logic [1:0] {
    ST_SYNC,
    ST_LOAD,
    ST_DONE
  } bsd_state_e;
  typedef logic [7:0] bsd_byte_t;
endpackage : bsd_pkg

// ==== common/bsd_stream_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface bsd_stream_if #(parameter int W = 8);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
  modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface : bsd_stream_if
`default_nettype wire

// ==== rtl/bsd_boot_loader.sv ====
// Overview of operation
// - fixed-length build takes exactly 256 bytes after sync, 257 in all
// - variable-length load ends after four character times of idle receive line
// - idle timeout is armed only once the sync character has arrived
// - after reset the sync character is awaited forever, no timeout
// - reset pin low with both mode selects low selects emulation mode
// - emulated data pins drive only while emulated output enable is active
// - boot map bit cleared hides boot rom, user rom shows through
// - boot map bit resets 0 and locked normally; 1 and writable in bootstrap
// - boot map bit set makes overlapping reads return boot rom data
// - transmitter double buffered: holding register plus shifter
// - each download character echo starts four clock cycles after reception
// - ones sync at fast rate selects fast baud, four character timeout
// - ones sync at slow rate selects slow baud, four character timeout
// - extended: F0 sync selects 9600 baud, 4.9 character timeout
// - extended: FD sync selects 5208 baud, 17.3 character timeout
// - zero or break as first character jumps to eeprom start
// - sync only, then idle, ends load and jumps to ram start
`timescale 1ns/100ps
`default_nettype none
`include "bsd_map.svh"
module bsd_boot_loader #(
  parameter int FAST_DIV = `BSD_CLK_HZ / `BSD_BAUD_FAST,
  parameter int SLOW_DIV = `BSD_CLK_HZ / `BSD_BAUD_SLOW,
  parameter int F0_DIV = `BSD_CLK_HZ / `BSD_BAUD_F0,
  parameter int FD_DIV = `BSD_CLK_HZ / `BSD_BAUD_FD,
  parameter bit FIXED = 1'b0,
  parameter bit EXTENDED = 1'b0,
  parameter int DEPTH = `BSD_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic rxd,
  output logic txd,
  input wire logic bootstrap_mode,
  input wire logic reset_pin_n,
  input wire logic [1:0] mode_sel,
  input wire logic emulated_output_enable_pin_n,
  input wire logic [7:0] ep_array_data,
  output logic [7:0] ep_data_o,
  output logic ep_data_oe,
  input wire logic map_wr,
  input wire logic map_wdata,
  output logic boot_rom_map_enable,
  input wire logic [15:0] rd_addr,
  input wire logic [7:0] boot_rom_data,
  input wire logic [7:0] user_rom_data,
  output logic [7:0] rd_data,
  output logic ram_wr,
  output logic [15:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic jump,
  output logic [15:0] jump_addr
);
  localparam int DW = 20;
  bsd_pkg::bsd_state_e st_q;
  logic [DW-1:0] div_q;
  logic slow_q;
  logic [7:0] to_lim_q;
  logic [7:0] to_bits_q;
  logic [DW-1:0] idle_tim_q;
  logic rx_busy_q;
  logic [3:0] rx_idx_q;
  logic [DW-1:0] rx_tim_q;
  logic [7:0] rx_sh_q;
  logic rx_valid_q;
  logic pend_q;
  bsd_pkg::bsd_byte_t pend_byte_q;
  logic [9:0] cnt_q;
  logic hold_full_q;
  bsd_pkg::bsd_byte_t hold_q;
  logic tx_busy_q;
  logic [9:0] tx_sh_q;
  logic [3:0] tx_idx_q;
  logic [DW-1:0] tx_tim_q;
  logic strap_done_q;
  logic push;
  logic timeout;

  bsd_stream_if #(.W(8)) echo_s ();

  // true when a cycle counter reaches its last count
  function automatic logic last_cyc(input logic [DW-1:0] c, input logic [DW-1:0] d);
    last_cyc = (c == d - 1'b1);
  endfunction : last_cyc

  // receiver: start edge, mid-bit sampling, lsb first, stop bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_busy_q <= 1'b0;
      rx_idx_q <= 4'h0;
      rx_tim_q <= '0;
      rx_sh_q <= 8'h00;
      rx_valid_q <= 1'b0;
    end else begin
      rx_valid_q <= 1'b0;
      if (!rx_busy_q) begin
        if (!rxd) begin
          rx_busy_q <= 1'b1;
          rx_idx_q <= 4'h0;
          rx_tim_q <= div_q >> 1;
        end
      end else if (last_cyc(rx_tim_q, div_q)) begin
        rx_tim_q <= '0;
        rx_idx_q <= rx_idx_q + 4'h1;
        if (rx_idx_q == 4'h0 && rxd) begin
          rx_busy_q <= 1'b0;
        end else if (rx_idx_q == 4'h9) begin
          rx_busy_q <= 1'b0;
          rx_valid_q <= 1'b1; // a break arrives as zero data
        end else if (rx_idx_q != 4'h0) begin
          rx_sh_q <= {rxd, rx_sh_q[7:1]};
        end
      end else begin
        rx_tim_q <= rx_tim_q + 1'b1;
      end
    end
  end

  // idle-line timer, counted in bit times, live only while loading
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      idle_tim_q <= '0;
      to_bits_q <= 8'h00;
    end else if (st_q != bsd_pkg::ST_LOAD || rx_busy_q || !rxd || pend_q) begin
      idle_tim_q <= '0;
      to_bits_q <= 8'h00;
    end else if (last_cyc(idle_tim_q, div_q)) begin
      idle_tim_q <= '0;
      to_bits_q <= to_bits_q + 8'h01;
    end else begin
      idle_tim_q <= idle_tim_q + 1'b1;
    end
  end
  assign timeout = !FIXED && (to_bits_q >= to_lim_q);

  // download sequencing: sync decode, load, jump
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= bsd_pkg::ST_SYNC;
      div_q <= DW'(FAST_DIV);
      slow_q <= 1'b0;
      to_lim_q <= `BSD_TO_FOUR;
      jump <= 1'b0;
      jump_addr <= 16'h0000;
    end else begin
      jump <= 1'b0;
      unique case (st_q)
        bsd_pkg::ST_SYNC: begin
          if (rx_valid_q) begin
            if (rx_sh_q == `BSD_SYNC_ZERO) begin
              st_q <= bsd_pkg::ST_DONE;
              jump <= 1'b1;
              jump_addr <= `BSD_EEPROM_BASE;
            end else if (rx_sh_q == `BSD_SYNC_ONES) begin
              st_q <= bsd_pkg::ST_LOAD;
              to_lim_q <= `BSD_TO_FOUR;
            end else if (EXTENDED && !slow_q && rx_sh_q == `BSD_SYNC_F0) begin
              st_q <= bsd_pkg::ST_LOAD;
              div_q <= DW'(F0_DIV);
              to_lim_q <= `BSD_TO_F0;
            end else if (EXTENDED && !slow_q && rx_sh_q == `BSD_SYNC_FD) begin
              st_q <= bsd_pkg::ST_LOAD;
              div_q <= DW'(FD_DIV);
              to_lim_q <= `BSD_TO_FD;
            end else begin
              slow_q <= ~slow_q; // retry at the other rate
              div_q <= slow_q ? DW'(FAST_DIV) : DW'(SLOW_DIV);
            end
          end
        end
        bsd_pkg::ST_LOAD: begin
          if (timeout || (FIXED && cnt_q == `BSD_FIXED_LEN) || cnt_q == `BSD_RAM_BYTES) begin
            st_q <= bsd_pkg::ST_DONE;
            jump <= 1'b1;
            jump_addr <= `BSD_RAM_BASE;
          end
        end
        bsd_pkg::ST_DONE: begin
          st_q <= bsd_pkg::ST_DONE;
        end
      endcase
    end
  end

  // catch a program byte, stall until the echo queue takes it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pend_q <= 1'b0;
      pend_byte_q <= 8'h00;
    end else begin
      if (rx_valid_q && st_q == bsd_pkg::ST_LOAD) begin
        pend_q <= 1'b1;
        pend_byte_q <= rx_sh_q;
      end else if (push) begin
        pend_q <= 1'b0;
      end
    end
  end
  assign push = pend_q && echo_s.wr_ready && st_q == bsd_pkg::ST_LOAD;
  assign echo_s.wr_valid = pend_q && st_q == bsd_pkg::ST_LOAD;
  assign echo_s.wr_data = pend_byte_q;

  // ram store at consecutive addresses from the base
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 10'h000;
      ram_wr <= 1'b0;
      ram_addr <= 16'h0000;
      ram_wdata <= 8'h00;
    end else begin
      ram_wr <= push;
      if (push) begin
        ram_addr <= `BSD_RAM_BASE + {6'h00, cnt_q};
        ram_wdata <= pend_byte_q;
        cnt_q <= cnt_q + 10'h001;
      end
    end
  end

  bsd_fifo #(.W(8), .D(DEPTH)) i_bsd_fifo (
    .clk(clk),
    .reset(reset),
    .s(echo_s)
  );

  // transmit holding register fed from the echo queue
  assign echo_s.rd_ready = !hold_full_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hold_full_q <= 1'b0;
      hold_q <= 8'h00;
    end else if (!hold_full_q && echo_s.rd_valid) begin
      hold_full_q <= 1'b1;
      hold_q <= echo_s.rd_data;
    end else if (hold_full_q && !tx_busy_q) begin
      hold_full_q <= 1'b0;
    end
  end

  // transmit shifter: start, eight data bits, stop
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_busy_q <= 1'b0;
      tx_sh_q <= 10'h3FF;
      tx_idx_q <= 4'h0;
      tx_tim_q <= '0;
      txd <= 1'b1;
    end else if (!tx_busy_q) begin
      if (hold_full_q) begin
        tx_busy_q <= 1'b1;
        tx_sh_q <= {1'b1, hold_q, 1'b0};
        tx_idx_q <= 4'h0;
        tx_tim_q <= '0;
        txd <= 1'b0;
      end
    end else if (last_cyc(tx_tim_q, div_q)) begin
      tx_tim_q <= '0;
      if (tx_idx_q == 4'h9) begin
        tx_busy_q <= 1'b0;
        txd <= 1'b1;
      end else begin
        tx_idx_q <= tx_idx_q + 4'h1;
        txd <= tx_sh_q[tx_idx_q + 4'h1];
      end
    end else begin
      tx_tim_q <= tx_tim_q + 1'b1;
    end
  end

  // eprom emulation pins while the reset pin is held low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ep_data_oe <= 1'b0;
      ep_data_o <= 8'h00;
    end else begin
      ep_data_oe <= !reset_pin_n && mode_sel == 2'b00 && !emulated_output_enable_pin_n;
      ep_data_o <= ep_array_data;
    end
  end

  // boot map bit: strap caught after release, locked outside bootstrap
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strap_done_q <= 1'b0;
      boot_rom_map_enable <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      boot_rom_map_enable <= bootstrap_mode;
    end else if (map_wr && bootstrap_mode) begin
      boot_rom_map_enable <= map_wdata;
    end
  end

  // read path: boot rom overlays user rom while mapped
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data <= 8'h00;
    end else if (boot_rom_map_enable && rd_addr >= `BSD_BOOT_LO && rd_addr <= `BSD_BOOT_HI) begin
      rd_data <= boot_rom_data;
    end else begin
      rd_data <= user_rom_data;
    end
  end

  sequence end_cond_s;
    st_q == bsd_pkg::ST_LOAD && timeout;
  endsequence
  sequence ram_jump_s;
    jump && jump_addr == `BSD_RAM_BASE && st_q == bsd_pkg::ST_DONE;
  endsequence

  sync_wait_a: assert property (@(posedge clk) disable iff (reset)
    st_q == bsd_pkg::ST_SYNC && !rx_valid_q |=> st_q == bsd_pkg::ST_SYNC)
    else $error("left sync wait without a character");
  to_armed_a: assert property (@(posedge clk) disable iff (reset)
    st_q != bsd_pkg::ST_LOAD |=> to_bits_q == 8'h00)
    else $error("idle timer ran before sync");
  idle_end_a: assert property (@(posedge clk) disable iff (reset)
    end_cond_s |=> ram_jump_s) else $error("idle timeout did not end load");
  zero_jump_a: assert property (@(posedge clk) disable iff (reset)
    st_q == bsd_pkg::ST_SYNC && rx_valid_q && rx_sh_q == 8'h00
    |=> jump && jump_addr == `BSD_EEPROM_BASE) else $error("zero did not jump");
  fixed_len_a: assert property (@(posedge clk) disable iff (reset)
    FIXED && st_q == bsd_pkg::ST_LOAD && cnt_q == `BSD_FIXED_LEN |=> ram_jump_s)
    else $error("fixed load did not end at length");
  emul_dir_a: assert property (@(posedge clk) disable iff (reset)
    ep_data_oe |-> $past(!reset_pin_n && mode_sel == 2'b00) && $past(!emulated_output_enable_pin_n))
    else $error("emulated data driven outside emulation");
  boot_read_a: assert property (@(posedge clk) disable iff (reset)
    boot_rom_map_enable && rd_addr == `BSD_BOOT_LO ##1 $stable(boot_rom_data)
    |-> rd_data == boot_rom_data) else $error("boot rom not overlaid");
  boot_lock_a: assert property (@(posedge clk) disable iff (reset)
    strap_done_q && !bootstrap_mode && !boot_rom_map_enable |=> !boot_rom_map_enable)
    else $error("boot map bit written outside bootstrap");
  tx_start_a: assert property (@(posedge clk) disable iff (reset)
    hold_full_q && !tx_busy_q |=> tx_busy_q && !txd ##1 !txd)
    else $error("holding register not moved to shifter");
endmodule : bsd_boot_loader
`default_nettype wire

// ==== rtl/bsd_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none
module bsd_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic reset,
  bsd_stream_if.fifo s
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // handshakes and honest flags
  assign s.wr_ready = (cnt_q != (AW+1)'(D));
  assign s.rd_valid = (cnt_q != '0);
  assign s.rd_data = mem_q[rp_q];
  assign push = s.wr_valid && s.wr_ready;
  assign pop = s.rd_valid && s.rd_ready;

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= s.wr_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  fifo_bound_a: assert property (@(posedge clk) disable iff (reset)
    cnt_q <= (AW+1)'(D)) else $error("fifo count beyond depth");
endmodule : bsd_fifo
`default_nettype wire

// ==== tb/bootstrap_serial_download_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "bsd_map.svh"
module bootstrap_serial_download_tb_top;
  logic clk, reset, rxd, txd, bootstrap_mode, reset_pin_n, oe_n, map_wr, map_wdata;
  logic boot_rom_map_enable, ep_data_oe, ram_wr, jump;
  logic [1:0] mode_sel;
  logic [7:0] ep_array_data, ep_data_o, boot_rom_data, user_rom_data, rd_data, ram_wdata;
  logic [15:0] rd_addr, ram_addr, jump_addr;
  logic [15:0] ra_q[$];
  logic [7:0] rw_q[$];
  int jump_n, fail_count, cmp_count;
  logic fx_rxd, fx_txd, fx_ram_wr, fx_jump;
  logic [15:0] fx_ram_addr, fx_addr, fx_jump_addr;
  logic [7:0] fx_ram_wdata, fx_data;
  int fx_n, fx_jump_n;
  bsd_boot_loader #(.FAST_DIV(16), .SLOW_DIV(40), .F0_DIV(20), .FD_DIV(30),
    .EXTENDED(1'b1)) i_bsd_boot_loader (
    .clk(clk), .reset(reset), .rxd(rxd), .txd(txd), .bootstrap_mode(bootstrap_mode),
    .reset_pin_n(reset_pin_n), .mode_sel(mode_sel), .emulated_output_enable_pin_n(oe_n),
    .ep_array_data(ep_array_data), .ep_data_o(ep_data_o), .ep_data_oe(ep_data_oe),
    .map_wr(map_wr), .map_wdata(map_wdata), .boot_rom_map_enable(boot_rom_map_enable),
    .rd_addr(rd_addr), .boot_rom_data(boot_rom_data), .user_rom_data(user_rom_data),
    .rd_data(rd_data), .ram_wr(ram_wr), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .jump(jump), .jump_addr(jump_addr));
  bsd_host_model i_bsd_host_model (.clk(clk), .rxd(rxd), .txd(txd));
  // second loader: fixed length, extended sync set, own host
  bsd_boot_loader #(.FAST_DIV(16), .SLOW_DIV(40), .F0_DIV(8), .FD_DIV(30), .FIXED(1'b1),
    .EXTENDED(1'b1)) i_bsd_boot_loader_fx (
    .clk(clk), .reset(reset), .rxd(fx_rxd), .txd(fx_txd), .bootstrap_mode(bootstrap_mode),
    .reset_pin_n(reset_pin_n), .mode_sel(mode_sel), .emulated_output_enable_pin_n(oe_n),
    .ep_array_data(ep_array_data), .ep_data_o(), .ep_data_oe(), .map_wr(map_wr),
    .map_wdata(map_wdata), .boot_rom_map_enable(), .rd_addr(rd_addr),
    .boot_rom_data(boot_rom_data), .user_rom_data(user_rom_data), .rd_data(),
    .ram_wr(fx_ram_wr), .ram_addr(fx_ram_addr), .ram_wdata(fx_ram_wdata), .jump(fx_jump),
    .jump_addr(fx_jump_addr));
  bsd_host_model i_bsd_host_model_fx (.clk(clk), .rxd(fx_rxd), .txd(fx_txd));
  // record ram writes and jumps of the fixed-length loader
  always @(posedge clk) begin
    if (fx_ram_wr === 1'b1) begin
      fx_n++;
      fx_addr = fx_ram_addr;
      fx_data = fx_ram_wdata;
    end
    if (fx_jump === 1'b1) fx_jump_n++;
  end
  // 100 mhz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // record ram writes and jumps
  always @(posedge clk) begin
    if (ram_wr === 1'b1) begin
      ra_q.push_back(ram_addr);
      rw_q.push_back(ram_wdata);
    end
    if (jump === 1'b1) jump_n++;
  end
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : cmp_val
  task automatic report_and_stop();
    $display("mismatches %0d of %0d compares", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic do_reset(input logic bm);
    reset = 1'b1;
    bootstrap_mode = bm;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    ra_q.delete();
    rw_q.delete();
    i_bsd_host_model.echo_q.delete();
    i_bsd_host_model_fx.echo_q.delete();
    jump_n = 0;
    fx_n = 0;
    fx_jump_n = 0;
    repeat (2) @(negedge clk);
  endtask : do_reset
  task automatic map_write(input logic v);
    map_wr = 1'b1;
    map_wdata = v;
    @(negedge clk);
    map_wr = 1'b0;
    @(negedge clk);
  endtask : map_write
  task automatic rd_at(input logic [15:0] a, input logic [7:0] exp);
    rd_addr = a;
    @(negedge clk);
    cmp_val(16'(rd_data), 16'(exp));
  endtask : rd_at
  task automatic wait_jump(input int lim);
    int n;
    n = 0;
    while (jump_n == 0 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_jump
  task automatic t_map();
    do_reset(1'b0);
    cmp_val(16'(boot_rom_map_enable), 16'h0000);
    map_write(1'b1);
    cmp_val(16'(boot_rom_map_enable), 16'h0000);
    do_reset(1'b1);
    cmp_val(16'(boot_rom_map_enable), 16'h0001);
    rd_at(`BSD_BOOT_LO, 8'hB5);
    rd_at(16'h1234, 8'h3C);
    map_write(1'b0);
    cmp_val(16'(boot_rom_map_enable), 16'h0000);
    rd_at(`BSD_BOOT_HI, 8'h3C);
    $display("test map done");
  endtask : t_map
  task automatic t_emul();
    reset_pin_n = 1'b0;
    mode_sel = 2'h0;
    oe_n = 1'b0;
    repeat (2) @(negedge clk);
    cmp_val(16'(ep_data_oe), 16'h0001);
    cmp_val(16'(ep_data_o), 16'h005A);
    oe_n = 1'b1;
    repeat (2) @(negedge clk);
    cmp_val(16'(ep_data_oe), 16'h0000);
    oe_n = 1'b0;
    mode_sel = 2'h1;
    repeat (2) @(negedge clk);
    cmp_val(16'(ep_data_oe), 16'h0000);
    reset_pin_n = 1'b1;
    mode_sel = 2'h0;
    repeat (2) @(negedge clk);
    cmp_val(16'(ep_data_oe), 16'h0000);
    $display("test emulation done");
  endtask : t_emul
  task automatic t_sync_only();
    do_reset(1'b1);
    repeat (3000) @(negedge clk);
    cmp_val(16'(jump_n), 16'h0000);
    i_bsd_host_model.send_byte(`BSD_SYNC_ONES, 16);
    repeat (400) @(negedge clk);
    cmp_val(16'(jump_n), 16'h0000);
    wait_jump(1500);
    cmp_val(16'(jump_n), 16'h0001);
    cmp_val(jump_addr, `BSD_RAM_BASE);
    cmp_val(16'(ra_q.size()), 16'h0000);
    $display("test sync only done");
  endtask : t_sync_only
  task automatic t_zero();
    do_reset(1'b1);
    i_bsd_host_model.send_byte(`BSD_SYNC_ZERO, 16);
    wait_jump(300);
    cmp_val(16'(jump_n), 16'h0001);
    cmp_val(jump_addr, `BSD_EEPROM_BASE);
    $display("test zero done");
  endtask : t_zero
  task automatic t_load();
    logic [7:0] pl[3];
    pl = '{8'hA1, 8'hB2, 8'hC3};
    do_reset(1'b1);
    i_bsd_host_model.send_byte(8'h55, 16);
    i_bsd_host_model.send_byte(`BSD_SYNC_ONES, 40);
    foreach (pl[i]) i_bsd_host_model.send_byte(pl[i], 40);
    wait_jump(2500);
    cmp_val(16'(ra_q.size()), 16'h0003);
    cmp_val(16'(i_bsd_host_model.echo_q.size()), 16'h0003);
    for (int i = 0; i < 3; i++) begin
      if (ra_q.size() > i) cmp_val(ra_q[i], `BSD_RAM_BASE + 16'(i));
      if (rw_q.size() > i) cmp_val(16'(rw_q[i]), 16'(pl[i]));
      if (i_bsd_host_model.echo_q.size() > i)
        cmp_val(16'(i_bsd_host_model.echo_q[i]), 16'(pl[i]));
    end
    cmp_val(16'(jump_n), 16'h0001);
    cmp_val(jump_addr, `BSD_RAM_BASE);
    $display("test load done");
  endtask : t_load
  task automatic t_fixed();
    do_reset(1'b1);
    i_bsd_host_model_fx.send_byte(`BSD_SYNC_F0, 16);
    for (int i = 0; i < 256; i++) begin
      if (i == 255) cmp_val(16'(fx_jump_n), 16'h0000);
      i_bsd_host_model_fx.send_byte(8'(i), 8);
    end
    cmp_val(16'(fx_jump_n), 16'h0001);
    i_bsd_host_model_fx.send_byte(8'h77, 8);
    repeat (200) @(negedge clk);
    cmp_val(16'(fx_n), 16'h0100);
    cmp_val(fx_addr, `BSD_RAM_BASE + 16'h00FF);
    cmp_val(16'(fx_data), 16'h00FF);
    cmp_val(fx_jump_addr, `BSD_RAM_BASE);
    cmp_val(16'(i_bsd_host_model_fx.echo_q.size()), 16'h0100);
    $display("test fixed length done");
  endtask : t_fixed
  task automatic t_fd();
    do_reset(1'b1);
    i_bsd_host_model.send_byte(`BSD_SYNC_FD, 16);
    i_bsd_host_model.send_byte(8'h42, 30);
    repeat (4500) @(negedge clk);
    cmp_val(16'(jump_n), 16'h0000);
    wait_jump(1500);
    cmp_val(16'(jump_n), 16'h0001);
    cmp_val(jump_addr, `BSD_RAM_BASE);
    cmp_val(16'(ra_q.size()), 16'h0001);
    if (rw_q.size() > 0) cmp_val(16'(rw_q[0]), 16'h0042);
    cmp_val(16'(i_bsd_host_model.echo_q.size()), 16'h0001);
    if (i_bsd_host_model.echo_q.size() > 0)
      cmp_val(16'(i_bsd_host_model.echo_q[0]), 16'h0042);
    $display("test fd sync done");
  endtask : t_fd
  // watchdog
  initial begin
    #800000;
    fail_count++;
    report_and_stop();
  end
  // main sequence
  initial begin
    reset = 1'b1;
    bootstrap_mode = 1'b1;
    reset_pin_n = 1'b1;
    mode_sel = 2'h0;
    oe_n = 1'b1;
    map_wr = 1'b0;
    map_wdata = 1'b0;
    ep_array_data = 8'h5A;
    boot_rom_data = 8'hB5;
    user_rom_data = 8'h3C;
    rd_addr = 16'h0000;
    jump_n = 0;
    fail_count = 0;
    cmp_count = 0;
    t_map();
    t_emul();
    t_sync_only();
    t_zero();
    t_load();
    t_fixed();
    t_fd();
    report_and_stop();
  end
endmodule : bootstrap_serial_download_tb_top
`default_nettype wire

// ==== tb/bsd_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module bsd_host_model (
  input wire logic clk,
  output logic rxd,
  input wire logic txd
);
  logic [7:0] echo_q[$];
  logic [7:0] sh;
  int div = 16;
  // line rests high between characters
  initial rxd = 1'b1;
  // one 8n1 character, lsb first, then a one bit gap
  task automatic send_byte(input logic [7:0] b, input int d);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    div = d;
    for (int i = 0; i < 10; i++) begin
      rxd = fr[i];
      repeat (d) @(negedge clk);
    end
    repeat (d) @(negedge clk); // gap far below the idle limit
  endtask : send_byte
  // echo receiver, samples mid bit
  initial begin
    forever begin
      @(negedge txd);
      repeat (div / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (div) @(posedge clk);
        sh[i] = txd;
      end
      repeat (div) @(posedge clk);
      echo_q.push_back(sh);
    end
  end
endmodule : bsd_host_model
`default_nettype wire
